// ### pkg/ssr_defines.svh
// secondary status/error register bank: offsets, field positions, reset values
// assumes inclusion by bare name from package and design files
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

`define SSR_ADDR_W 7
`define SSR_WORD_W 16
`define SSR_LIVE_STATUS_ADDR 7'h12
`define SSR_STICKY_ERRORS_ADDR 7'h13

// low bits shared by the live and error words; unmapped reads carry only parity
`define SSR_PARITY_BIT 0
`define SSR_REJECT_BIT 1

// live status fields
`define SSR_CLAMP_INHIBIT_LEVEL_BIT 8
`define SSR_IO_LEVEL_BIT 7
`define SSR_UV_LIVE_BIT 6
`define SSR_OC_COMP_BIT 5
`define SSR_SAT_COMP_BIT 4

// sticky error fields
`define SSR_HARD_RESET_BIT 15
`define SSR_OC_ERR_BIT 14
`define SSR_SAT_ERR_BIT 13
`define SSR_UV_ERR_BIT 12
`define SSR_VER_TIMEOUT_BIT 9
`define SSR_ADC_UPPER_BIT 6
`define SSR_ADC_LOWER_BIT 5
`define SSR_LINK_LOSS_BIT 4

// synchronised inputs: clamp pin, io pin, uv live, oc comp, sat comp
`define SSR_SYNC_W 5
`define SSR_SYNC_CLAMP 0
`define SSR_SYNC_IO 1
`define SSR_SYNC_UV 2
`define SSR_SYNC_OC 3
`define SSR_SYNC_SAT 4

`define SSR_WORD_RESET 16'h0000
`define SSR_FLAG_RESET 1'b0
`define SSR_HARD_RESET_INIT 1'b1

`endif

// ### pkg/ssr_pkg.sv
// types shared by the secondary status/error register bank
// assumes ssr_defines.svh is on the include path
`default_nettype none

`include "ssr_defines.svh"

package ssr_pkg;
  typedef logic [`SSR_WORD_W-1:0] ssr_word_t;
  typedef logic [`SSR_ADDR_W-1:0] ssr_addr_t;
  typedef logic [`SSR_SYNC_W-1:0] ssr_sync_t;
  typedef enum logic [1:0] {
    SSR_SEL_NONE,
    SSR_SEL_LIVE,
    SSR_SEL_ERRORS
  } ssr_sel_t;
endpackage

`default_nettype wire

// ### design/ssr_sync.sv
// two-flop synchroniser bank for pin and comparator levels
// assumes levels are quasi-static relative to ref_clk; no pulse is stretched
`default_nettype none

`include "ssr_defines.svh"

module ssr_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ssr_pkg::ssr_sync_t async_in,
  output ssr_pkg::ssr_sync_t sync_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;

  ssr_sync_t meta_q;
  ssr_sync_t sync_q;

  // meta_q feeds only sync_q
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

`default_nettype wire

// ### design/ssr_regs.sv
// secondary live status word and sticky error word, read by address
// assumes the frame logic gives rd_en/rd_addr, clear pulses and the reject bit on ref_clk
`default_nettype none

`include "ssr_defines.svh"

module ssr_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire ssr_pkg::ssr_addr_t rd_addr,
  output ssr_pkg::ssr_word_t rd_data,
  output logic rd_valid,
  input wire logic clr_en,
  input wire ssr_pkg::ssr_word_t clr_mask,
  input wire logic last_frame_rejected,
  input wire logic clamp_inhibit_pin,
  input wire logic secondary_io_pin,
  input wire logic supply_undervoltage_live,
  input wire logic overcurrent_comparator_out,
  input wire logic saturation_comparator_out,
  input wire logic overcurrent_event,
  input wire logic saturation_event,
  input wire logic verification_timeout_event,
  input wire logic adc_upper_bound_event,
  input wire logic adc_lower_bound_event,
  input wire logic primary_link_loss_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // odd parity over the whole word: bit 0 makes the count of ones odd
  function automatic ssr_word_t add_parity(input ssr_word_t w);
    ssr_word_t r;
    r = w;
    r[`SSR_PARITY_BIT] = ~(^w[`SSR_WORD_W-1:1]);
    return r;
  endfunction

  // set wins over clear; a blocked clear leaves the flag as it is
  function automatic logic sticky_next(input logic cur, input logic set,
                                       input logic clr, input logic hold);
    logic r;
    r = cur;
    if (set) begin
      r = 1'b1;
    end else if (clr && !hold) begin
      r = 1'b0;
    end
    return r;
  endfunction

  function automatic ssr_sel_t decode(input ssr_addr_t a);
    ssr_sel_t s;
    s = SSR_SEL_NONE;
    if (a == `SSR_LIVE_STATUS_ADDR) begin
      s = SSR_SEL_LIVE;
    end else if (a == `SSR_STICKY_ERRORS_ADDR) begin
      s = SSR_SEL_ERRORS;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  ssr_sync_t raw_levels;
  ssr_sync_t sync_levels;

  always_comb begin
    raw_levels = '0;
    raw_levels[`SSR_SYNC_CLAMP] = clamp_inhibit_pin;
    raw_levels[`SSR_SYNC_IO] = secondary_io_pin;
    raw_levels[`SSR_SYNC_UV] = supply_undervoltage_live;
    raw_levels[`SSR_SYNC_OC] = overcurrent_comparator_out;
    raw_levels[`SSR_SYNC_SAT] = saturation_comparator_out;
  end

  ssr_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(raw_levels),
    .sync_out(sync_levels)
  );

  logic clamp_inhibit_level;
  logic secondary_io_level;
  logic uv_live;
  logic oc_comp;
  logic sat_comp;

  assign clamp_inhibit_level = sync_levels[`SSR_SYNC_CLAMP];
  assign secondary_io_level = sync_levels[`SSR_SYNC_IO];
  assign uv_live = sync_levels[`SSR_SYNC_UV];
  assign oc_comp = sync_levels[`SSR_SYNC_OC];
  assign sat_comp = sync_levels[`SSR_SYNC_SAT];

  ////////////////////////////////////////////////////////////////////////////
  // sticky error flags

  logic hard_reset_q;
  logic oc_err_q;
  logic sat_err_q;
  logic uv_err_q;
  logic ver_timeout_q;
  logic adc_upper_q;
  logic adc_lower_q;
  logic link_loss_q;

  function automatic logic clr_bit(input logic en, input ssr_word_t m, input int unsigned b);
    return en & m[b];
  endfunction

  // power-up of the secondary supply is what asserts rst_n here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_reset_q <= `SSR_HARD_RESET_INIT;
    end else begin
      hard_reset_q <= sticky_next(hard_reset_q, 1'b0,
                                  clr_bit(clr_en, clr_mask, `SSR_HARD_RESET_BIT), 1'b0);
    end
  end

  // set by the event input; a clear is held off while the synchronised comparator is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_err_q <= `SSR_FLAG_RESET;
    end else begin
      oc_err_q <= sticky_next(oc_err_q, overcurrent_event,
                              clr_bit(clr_en, clr_mask, `SSR_OC_ERR_BIT), oc_comp);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_err_q <= `SSR_FLAG_RESET;
    end else begin
      sat_err_q <= sticky_next(sat_err_q, saturation_event,
                               clr_bit(clr_en, clr_mask, `SSR_SAT_ERR_BIT), 1'b0);
    end
  end

  // lockout source is the synchronised live monitor itself
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_err_q <= `SSR_FLAG_RESET;
    end else begin
      uv_err_q <= sticky_next(uv_err_q, uv_live,
                              clr_bit(clr_en, clr_mask, `SSR_UV_ERR_BIT), uv_live);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ver_timeout_q <= `SSR_FLAG_RESET;
    end else begin
      ver_timeout_q <= sticky_next(ver_timeout_q, verification_timeout_event,
                                   clr_bit(clr_en, clr_mask, `SSR_VER_TIMEOUT_BIT), 1'b0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_upper_q <= `SSR_FLAG_RESET;
    end else begin
      adc_upper_q <= sticky_next(adc_upper_q, adc_upper_bound_event,
                                 clr_bit(clr_en, clr_mask, `SSR_ADC_UPPER_BIT), 1'b0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_lower_q <= `SSR_FLAG_RESET;
    end else begin
      adc_lower_q <= sticky_next(adc_lower_q, adc_lower_bound_event,
                                 clr_bit(clr_en, clr_mask, `SSR_ADC_LOWER_BIT), 1'b0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_loss_q <= `SSR_FLAG_RESET;
    end else begin
      link_loss_q <= sticky_next(link_loss_q, primary_link_loss_event,
                                 clr_bit(clr_en, clr_mask, `SSR_LINK_LOSS_BIT), 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word assembly

  ssr_word_t live_word;
  ssr_word_t error_word;

  // reserved bits stay zero from the initial clear
  always_comb begin
    live_word = '0;
    live_word[`SSR_CLAMP_INHIBIT_LEVEL_BIT] = clamp_inhibit_level;
    live_word[`SSR_IO_LEVEL_BIT] = secondary_io_level;
    live_word[`SSR_UV_LIVE_BIT] = uv_live;
    live_word[`SSR_OC_COMP_BIT] = oc_comp;
    live_word[`SSR_SAT_COMP_BIT] = sat_comp;
    live_word[`SSR_REJECT_BIT] = last_frame_rejected;
  end

  always_comb begin
    error_word = '0;
    error_word[`SSR_HARD_RESET_BIT] = hard_reset_q;
    error_word[`SSR_OC_ERR_BIT] = oc_err_q;
    error_word[`SSR_SAT_ERR_BIT] = sat_err_q;
    error_word[`SSR_UV_ERR_BIT] = uv_err_q;
    error_word[`SSR_VER_TIMEOUT_BIT] = ver_timeout_q;
    error_word[`SSR_ADC_UPPER_BIT] = adc_upper_q;
    error_word[`SSR_ADC_LOWER_BIT] = adc_lower_q;
    error_word[`SSR_LINK_LOSS_BIT] = link_loss_q;
    error_word[`SSR_REJECT_BIT] = last_frame_rejected;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  ssr_word_t rd_data_q;
  logic rd_valid_q;
  ssr_word_t sel_word;

  // unmapped addresses answer a zero word, still with valid parity
  always_comb begin
    sel_word = '0;
    case (decode(rd_addr))
      SSR_SEL_LIVE: begin
        sel_word = live_word;
      end
      SSR_SEL_ERRORS: begin
        sel_word = error_word;
      end
      default: begin
        sel_word = '0;
      end
    endcase
  end

  // the captured word is a snapshot; later flag changes do not disturb it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= `SSR_WORD_RESET;
    end else if (rd_en) begin
      rd_data_q <= add_parity(sel_word);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
endmodule

`default_nettype wire

// ### sim/ssr_regs_properties.sv
// read-port assertions for the status/error register bank
// bound to ssr_regs from the bench top; sees only its ports
`default_nettype none
`include "ssr_defines.svh"
module ssr_regs_properties
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire ssr_pkg::ssr_addr_t rd_addr,
  input wire ssr_pkg::ssr_word_t rd_data,
  input wire logic rd_valid,
  input wire logic clr_en,
  input wire logic last_frame_rejected,
  input wire logic clamp_inhibit_pin,
  input wire logic secondary_io_pin,
  input wire logic supply_undervoltage_live,
  input wire logic overcurrent_comparator_out,
  input wire logic saturation_comparator_out,
  input wire logic overcurrent_event,
  input wire logic saturation_event
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam ssr_addr_t LA = `SSR_LIVE_STATUS_ADDR;
  localparam ssr_addr_t EA = `SSR_STICKY_ERRORS_ADDR;
  logic [4:0] lv;
  logic [4:0] q1_q, q2_q, q3_q;
  logic st;
  assign lv = {clamp_inhibit_pin, secondary_io_pin, supply_undervoltage_live,
    overcurrent_comparator_out, saturation_comparator_out};
  // levels cross two flops, so only judge reads after four steady samples
  assign st = (lv == q1_q) && (q1_q == q2_q) && (q2_q == q3_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q1_q <= 5'h00;
      q2_q <= 5'h00;
      q3_q <= 5'h00;
    end else begin
      q1_q <= lv;
      q2_q <= q1_q;
      q3_q <= q2_q;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  valid_timing_a: assert property (rd_valid == $past(rd_en))
    else $error("rd_valid not one cycle after rd_en");
  odd_parity_a: assert property (rd_valid |-> ^rd_data)
    else $error("read word parity even");
  unmapped_zero_a: assert property (rd_en && rd_addr != LA && rd_addr != EA
    |=> rd_data == 16'h0001) else $error("unmapped read not 0001");
  reject_bit_a: assert property (rd_en && (rd_addr == LA || rd_addr == EA)
    |=> rd_data[1] == $past(last_frame_rejected)) else $error("reject bit wrong");
  live_reserved_a: assert property (rd_en && rd_addr == LA
    |=> rd_data[15:9] == 7'h00 && rd_data[3:2] == 2'h0) else $error("live reserved set");
  err_reserved_a: assert property (rd_en && rd_addr == EA
    |=> rd_data[11:10] == 2'h0 && rd_data[8:7] == 2'h0 && rd_data[3:2] == 2'h0)
    else $error("error reserved set");
  pin_levels_a: assert property (rd_en && rd_addr == LA && st
    |=> rd_data[8:7] == $past(lv[4:3])) else $error("pin level bits wrong");
  monitor_levels_a: assert property (rd_en && rd_addr == LA && st
    |=> rd_data[6:4] == $past(lv[2:0])) else $error("monitor bits wrong");
  oc_sticky_a: assert property (overcurrent_event ##1 !clr_en ##1 rd_en && rd_addr == EA
    |=> rd_data[14]) else $error("overcurrent flag not latched");
  sat_sticky_a: assert property (saturation_event ##1 !clr_en ##1 rd_en && rd_addr == EA
    |=> rd_data[13]) else $error("saturation flag not latched");
  cover property (rd_valid && rd_data == 16'h0001);
  cover property (rd_en && rd_addr == LA && st && last_frame_rejected);
  cover property (overcurrent_event ##2 rd_en && rd_addr == EA);
endmodule
`default_nettype wire

// ### sim/ssr_host_model.sv
// host side of the register bank: issues reads and clear requests
// assumes ssr_regs takes requests one clock after they are raised
`default_nettype none
module ssr_host_model
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  output logic rd_en,
  output ssr_pkg::ssr_addr_t rd_addr,
  output logic clr_en,
  output ssr_pkg::ssr_word_t clr_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
    clr_en = 1'b0;
    clr_mask = 16'h0000;
  end
  // released qualifiers flip so a stale value is never mistaken for a live one
  task automatic rd(input ssr_addr_t a);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
  endtask
  task automatic clr(input ssr_word_t m);
    @(posedge ref_clk);
    clr_en <= 1'b1;
    clr_mask <= m;
    @(posedge ref_clk);
    clr_en <= 1'b0;
    clr_mask <= ~m;
  endtask
endmodule
`default_nettype wire

// ### sim/ssr_regs_tb_top.sv
// self-checking bench for the status/error register bank
// assumes ssr_host_model and ssr_regs_properties are compiled first
`default_nettype none
module ssr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;
  logic ref_clk, rst_n, rd_en, rd_valid, clr_en, rej;
  ssr_addr_t rd_addr;
  ssr_word_t rd_data, clr_mask, err;
  logic [4:0] lv;
  logic [5:0] ev;
  logic [31:0] seed, r;
  int fail_count, n_checks;
  ssr_word_t exp_q[$];
  ssr_word_t mk[6] = '{16'h4000, 16'h2000, 16'h0200, 16'h0040, 16'h0020, 16'h0010};
  ssr_host_model ssr_host_model_inst (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .clr_en(clr_en), .clr_mask(clr_mask));
  ssr_regs ssr_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .clr_en(clr_en),
    .clr_mask(clr_mask), .last_frame_rejected(rej), .clamp_inhibit_pin(lv[4]),
    .secondary_io_pin(lv[3]), .supply_undervoltage_live(lv[2]),
    .overcurrent_comparator_out(lv[1]), .saturation_comparator_out(lv[0]),
    .overcurrent_event(ev[5]), .saturation_event(ev[4]),
    .verification_timeout_event(ev[3]), .adc_upper_bound_event(ev[2]),
    .adc_lower_bound_event(ev[1]), .primary_link_loss_event(ev[0]));
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // adds the reject bit and odd parity to a flag pattern
  function automatic ssr_word_t fix(input ssr_word_t w);
    w[1] = rej;
    w[0] = ~^w[15:1];
    return w;
  endfunction
  task automatic rdx(input ssr_addr_t a, input ssr_word_t e);
    exp_q.push_back(e);
    ssr_host_model_inst.rd(a);
  endtask
  task automatic cmp(input ssr_word_t e, input ssr_word_t g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value rd_data expected %h seen %h", e, g);
    end
  endtask
  task automatic close_out();
    // a read still waiting for its answer means the bank went quiet
    if (exp_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp(16'hFFFF, rd_data);
      else cmp(exp_q.pop_front(), rd_data);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    lv = 5'h00;
    ev = 6'h00;
    rej = 1'b0;
    seed = 32'h0001_2165;
    err = 16'h8000;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdx(7'h13, fix(16'h8000));
    rdx(7'h12, fix(16'h0000));
    rdx(7'h00, 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = xs();
      @(posedge ref_clk);
      lv <= r[4:0];
      rej <= r[5];
      repeat (3) @(posedge ref_clk);
      if (r[2]) err |= 16'h1000;
      rdx(7'h12, fix({7'h00, r[4:0], 4'h0}));
      rdx(7'h13, fix(err));
    end
    @(posedge ref_clk);
    lv <= 5'h00;
    repeat (3) @(posedge ref_clk);
    ssr_host_model_inst.clr(16'hFFFF);
    rdx(7'h13, fix(16'h0000));
    $display("test live levels done");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      ev <= 6'h20 >> i;
      @(posedge ref_clk);
      ev <= 6'h00;
      rdx(7'h13, fix(mk[i]));
      ssr_host_model_inst.clr(mk[i]);
      rdx(7'h13, fix(16'h0000));
    end
    @(posedge ref_clk);
    ev <= 6'h01;
    ssr_host_model_inst.clr(16'h0010);
    rdx(7'h13, fix(16'h0010));
    $display("test event flags done");
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      ev <= (i == 0) ? 6'h20 : 6'h00;
      lv <= (i == 0) ? 5'h02 : 5'h04;
      @(posedge ref_clk);
      ev <= 6'h00;
      repeat (3) @(posedge ref_clk);
      ssr_host_model_inst.clr(16'h5010);
      rdx(7'h13, fix((i == 0) ? 16'h4000 : 16'h1000));
      @(posedge ref_clk);
      lv <= 5'h00;
      repeat (3) @(posedge ref_clk);
      ssr_host_model_inst.clr(16'h5000);
      rdx(7'h13, fix(16'h0000));
    end
    $display("test blocked clear done");
    repeat (4) @(posedge ref_clk);
    close_out();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
endmodule
bind ssr_regs ssr_regs_properties ssr_regs_properties_inst (.ref_clk, .rst_n, .rd_en,
  .rd_addr, .rd_data, .rd_valid, .clr_en, .last_frame_rejected, .clamp_inhibit_pin,
  .secondary_io_pin, .supply_undervoltage_live, .overcurrent_comparator_out,
  .saturation_comparator_out, .overcurrent_event, .saturation_event);
`default_nettype wire
